// ===== verilog/area_decode_pkg.sv
package area_decode_pkg;

    // ----------------------------------------------------------------
    // Address fields
    // ----------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int AREA_HI = 28;          // Area number sits in bits 28..26
    localparam int AREA_LO = 26;
    localparam logic [2:0] AREA_FLASH = 3'h0;
    localparam logic [2:0] AREA_SLOT1 = 3'h1;
    localparam logic [2:0] AREA_DISPLAY = 3'h2;
    localparam logic [2:0] AREA_SDRAM = 3'h3;
    localparam logic [2:0] AREA_SLOT2 = 3'h4;
    localparam logic [2:0] AREA_SLOT3 = 3'h5;
    localparam logic [2:0] AREA_PERIPH = 3'h6;

    // Top nibble selects the local space (0 or 1) or the PCI space (F)
    localparam logic [2:0] TOP_LOCAL = 3'h0;
    localparam logic [3:0] TOP_PCI = 4'hF;
    localparam int TOP_LO = 29;           // Local space tag is bits 31..29
    localparam int PCI_NIB_LO = 28;       // PCI space tag is bits 31..28

    // Flash area: bits 25..24 nonzero are unused, bit 23 is the image bit
    localparam int FLASH_UNUSED_BIT = 24;
    localparam int FLASH_IMAGE_BIT = 23;
    localparam int FLASH_AW = 23;         // 8 MB
    localparam int SLOT_AW = 19;          // 512 KB
    localparam int DISPLAY_AW = 22;       // 4 MB

    // Peripheral area sub-decode, bits 25..23
    localparam int SUB_HI = 25;
    localparam int SUB_LO = 23;
    localparam logic [2:0] SUB_SERIAL_A = 3'h4;
    localparam logic [2:0] SUB_SERIAL_B = 3'h5;
    localparam logic [2:0] SUB_CONTROL = 3'h6;
    localparam int CARD_BIT = 25;         // Clear: first 32 MB is the card
    localparam int SERIAL_AW = 4;         // 16 bytes
    localparam int CONTROL_AW = 8;        // 256 bytes

    // PCI windows, bits 31..24 (memory) or 31..18 (register/IO) compared
    localparam int PCI_MEM_LO = 24;       // Memory window tag bits 31..24
    localparam int PCI_REG_LO = 18;       // Register window tag bits 31..18
    localparam logic [7:0] PCI_MEM_TOP = 8'hFD;
    localparam logic [13:0] PCI_REG_TOP = 14'h3F88;  // FE200000 >> 18

    // ----------------------------------------------------------------
    // Decoded selects
    // ----------------------------------------------------------------
    typedef struct packed {
        logic flash;
        logic eprom;
        logic display_controller;
        logic sdram;
        logic card;
        logic serial_a;
        logic serial_b;
        logic control;
        logic pci_mem;
        logic pci_reg_io;
    } dev_sel_t;

    typedef struct packed {
        logic slot_select_first_n;
        logic slot_select_second_n;
        logic slot_select_third_n;
    } slot_sel_t;

    localparam slot_sel_t SLOT_IDLE = 3'h7;
    localparam dev_sel_t DEV_IDLE = 10'h000;

endpackage : area_decode_pkg

// ===== verilog/area_decoder.sv
// Overview of operation
// - Area one accesses drive first slot select low; real window 512 KB.
// - Area four accesses drive second slot select low; real window 512 KB.
// - Area five accesses drive third slot select low; real window 512 KB.
// - Slot window repeats as images up to each area end.
// - Flash 8 MB at bottom of area zero, imaged once; rest unused.
// - Without debug board, area zero is flash only; swap switch ignored.
// - With debug board, flash and EPROM both reachable; switch swaps them.
// - Area two selects display controller 4 MB window, imaged to area end.
// - Area three is 64 MB SDRAM on 32-bit path; others 16-bit.
// - Area six first 32 MB is card controller, then sub-decoded.
// - Serial A: 16 bytes at sub-area base, imaged through 8 MB.
// - Serial B: 16 bytes at next sub-area base, imaged through 8 MB.
// - Control block 256 bytes imaged to 8 MB; following 8 MB unused.
// - Area seven reserved for PCI: 16 MB memory, 256 KB register/IO.
`timescale 1ns/1ps
module area_decoder
    import area_decode_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Local bus access
    input wire logic i_access,
    input wire logic [area_decode_pkg::ADDR_W-1:0] i_addr,
    // Board straps
    input wire logic i_debug_board_fitted,
    input wire logic i_eprom_first,
    // Selects
    output area_decode_pkg::dev_sel_t o_dev_sel,
    output area_decode_pkg::slot_sel_t o_slot_sel,
    output logic o_bus_32bit,
    output logic [area_decode_pkg::SLOT_AW-1:0] o_slot_addr,
    output logic [area_decode_pkg::FLASH_AW-1:0] o_mem_addr
);
    import area_decode_pkg::*;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    dev_sel_t dev_sel_reg, dev_sel_next;
    slot_sel_t slot_sel_reg, slot_sel_next;
    logic bus_32bit_reg, bus_32bit_next;
    logic [SLOT_AW-1:0] slot_addr_reg, slot_addr_next;
    logic [FLASH_AW-1:0] mem_addr_reg, mem_addr_next;

    logic local_space;
    logic [2:0] area;
    logic [2:0] sub;
    logic upper_half;

    // Address fields of the current access
    assign local_space = (i_addr[ADDR_W-1:TOP_LO] == TOP_LOCAL);
    assign area = i_addr[AREA_HI:AREA_LO];
    assign sub = i_addr[SUB_HI:SUB_LO];
    assign upper_half = i_addr[FLASH_IMAGE_BIT];

    // Next selects; anything not matched leaves every select idle
    always_comb
    begin
        dev_sel_next = DEV_IDLE;
        slot_sel_next = SLOT_IDLE;
        bus_32bit_next = 1'b0;
        // Upper address bits dropped so windows image across the area
        slot_addr_next = i_addr[SLOT_AW-1:0];
        mem_addr_next = i_addr[FLASH_AW-1:0];
        if (i_access && local_space)
        begin
            unique case (area)
                AREA_FLASH:
                begin
                    // Both bits above the image bit clear: flash or image
                    if (i_addr[AREA_LO-1:FLASH_UNUSED_BIT] == '0)
                    begin
                        if (!i_debug_board_fitted)
                            dev_sel_next.flash = 1'b1;
                        else if (upper_half ^ i_eprom_first)
                            dev_sel_next.eprom = 1'b1;
                        else
                            dev_sel_next.flash = 1'b1;
                    end
                end
                AREA_SLOT1: slot_sel_next.slot_select_first_n = 1'b0;
                AREA_SLOT2: slot_sel_next.slot_select_second_n = 1'b0;
                AREA_SLOT3: slot_sel_next.slot_select_third_n = 1'b0;
                AREA_DISPLAY: dev_sel_next.display_controller = 1'b1;
                AREA_SDRAM:
                begin
                    dev_sel_next.sdram = 1'b1;
                    bus_32bit_next = 1'b1;
                end
                AREA_PERIPH:
                begin
                    if (!i_addr[CARD_BIT])
                        dev_sel_next.card = 1'b1;
                    else if (sub == SUB_SERIAL_A)
                        dev_sel_next.serial_a = 1'b1;
                    else if (sub == SUB_SERIAL_B)
                        dev_sel_next.serial_b = 1'b1;
                    else if (sub == SUB_CONTROL)
                        dev_sel_next.control = 1'b1;
                end
                default:
                begin
                    dev_sel_next = DEV_IDLE;  // Area seven local: unused
                end
            endcase
        end
        else if (i_access && i_addr[ADDR_W-1:PCI_NIB_LO] == TOP_PCI)
        begin
            if (i_addr[ADDR_W-1:PCI_MEM_LO] == PCI_MEM_TOP)
                dev_sel_next.pci_mem = 1'b1;
            else if (i_addr[ADDR_W-1:PCI_REG_LO] == PCI_REG_TOP)
                dev_sel_next.pci_reg_io = 1'b1;
        end
    end

    // Select registers
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            dev_sel_reg <= DEV_IDLE;
            slot_sel_reg <= SLOT_IDLE;
            bus_32bit_reg <= 1'b0;
            slot_addr_reg <= '0;
            mem_addr_reg <= '0;
        end
        else
        begin
            dev_sel_reg <= dev_sel_next;
            slot_sel_reg <= slot_sel_next;
            bus_32bit_reg <= bus_32bit_next;
            slot_addr_reg <= slot_addr_next;
            mem_addr_reg <= mem_addr_next;
        end
    end

    assign o_dev_sel = dev_sel_reg;
    assign o_slot_sel = slot_sel_reg;
    assign o_bus_32bit = bus_32bit_reg;
    assign o_slot_addr = slot_addr_reg;
    assign o_mem_addr = mem_addr_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic taken;

    // An access sampled while reset still holds the registers is not taken
    assign taken = i_access && !i_rst;

    sequence s_slot1_access;
        taken && i_addr[31:26] == 6'h01;
    endsequence

    a_slot_one_select: assert property (@(posedge i_core_clk)
        disable iff (i_rst) s_slot1_access |=>
        !o_slot_sel.slot_select_first_n && o_slot_sel.slot_select_second_n)
        else $error("first slot select not asserted");

    a_slot_two_select: assert property (@(posedge i_core_clk)
        disable iff (i_rst) taken && i_addr[31:26] == 6'h04 |=>
        !o_slot_sel.slot_select_second_n)
        else $error("second slot select not asserted");

    a_slot_three_select: assert property (@(posedge i_core_clk)
        disable iff (i_rst) taken && i_addr[31:26] == 6'h05 |=>
        !o_slot_sel.slot_select_third_n)
        else $error("third slot select not asserted");

    a_slot_image_addr: assert property (@(posedge i_core_clk)
        disable iff (i_rst) s_slot1_access |=>
        o_slot_addr == $past(i_addr[SLOT_AW-1:0]))
        else $error("slot image address wrong");

    a_flash_unused_span: assert property (@(posedge i_core_clk)
        disable iff (i_rst) taken && i_addr[31:26] == 6'h00 &&
        i_addr[25:24] != 2'h0 |=> !o_dev_sel.flash && !o_dev_sel.eprom)
        else $error("flash unused span selected");

    a_no_board_flash: assert property (@(posedge i_core_clk)
        disable iff (i_rst) taken && i_addr[31:24] == 8'h00 &&
        !i_debug_board_fitted |=> o_dev_sel.flash && !o_dev_sel.eprom)
        else $error("flash only decode broken");

    a_swap_eprom: assert property (@(posedge i_core_clk)
        disable iff (i_rst) taken && i_addr[31:23] == 9'h000 &&
        i_debug_board_fitted && i_eprom_first |=> o_dev_sel.eprom)
        else $error("eprom swap not honoured");

    a_display_image: assert property (@(posedge i_core_clk)
        disable iff (i_rst) taken && i_addr[31:26] == 6'h02 |=>
        o_dev_sel.display_controller && !o_bus_32bit)
        else $error("display controller not selected");

    a_sdram_wide: assert property (@(posedge i_core_clk)
        disable iff (i_rst) taken && i_addr[31:26] == 6'h03 |=>
        o_dev_sel.sdram && o_bus_32bit)
        else $error("sdram decode wrong");

    a_card_select: assert property (@(posedge i_core_clk)
        disable iff (i_rst) taken && i_addr[31:25] == 7'h0C |=>
        o_dev_sel.card && !o_dev_sel.serial_a)
        else $error("card controller not selected");

    a_serial_b_image: assert property (@(posedge i_core_clk)
        disable iff (i_rst) taken && i_addr[31:23] == 9'h035 |=>
        o_dev_sel.serial_b && !o_dev_sel.serial_a)
        else $error("serial b not selected");

    a_control_image: assert property (@(posedge i_core_clk)
        disable iff (i_rst) taken && i_addr[31:23] == 9'h036 |=>
        o_dev_sel.control && !o_dev_sel.serial_b)
        else $error("control block not selected");

    a_pci_mem_window: assert property (@(posedge i_core_clk)
        disable iff (i_rst) taken && i_addr[31:24] == 8'hFD |=>
        o_dev_sel.pci_mem && !o_dev_sel.pci_reg_io)
        else $error("pci memory window not selected");

    a_idle_unused: assert property (@(posedge i_core_clk)
        disable iff (i_rst) taken && i_addr[31:23] == 9'h037 |=>
        o_dev_sel == DEV_IDLE && o_slot_sel == SLOT_IDLE)
        else $error("unused span selected something");

endmodule : area_decoder

// ===== test/slot_board_model.sv
`timescale 1ns/1ps
module slot_board_model
    import area_decode_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Slot selects seen at the expansion connector
    input area_decode_pkg::slot_sel_t i_slot_sel,
    // Board observations
    output logic o_clash,
    output logic [7:0] o_hits
);
    logic clash_reg;
    logic clash_next;
    logic [7:0] hits_reg;
    logic [7:0] hits_next;

    // Two boards selected at once is a clash; count selected cycles
    always_comb
    begin
        clash_next = clash_reg | ($countones(~i_slot_sel) > 1);
        hits_next = hits_reg + 8'(i_slot_sel != SLOT_IDLE);
    end

    // Observation registers
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            clash_reg <= 1'h0;
            hits_reg <= 8'h00;
        end
        else
        begin
            clash_reg <= clash_next;
            hits_reg <= hits_next;
        end
    end

    assign o_clash = clash_reg;
    assign o_hits = hits_reg;
endmodule : slot_board_model

// ===== test/area_decoder_tb_top.sv
`timescale 1ns/1ps
module area_decoder_tb_top;
    import area_decode_pkg::*;
    typedef struct packed {
        logic [31:0] addr;
        logic [1:0] sw;
        dev_sel_t dev;
        slot_sel_t slot;
        logic b32;
    } row_t;
    logic i_core_clk = 1'h0;
    logic i_rst = 1'h1;
    logic i_access = 1'h0;
    logic [31:0] i_addr = 32'h0;
    logic i_debug_board_fitted = 1'h0;
    logic i_eprom_first = 1'h0;
    dev_sel_t o_dev_sel;
    slot_sel_t o_slot_sel;
    logic o_bus_32bit;
    logic [18:0] o_slot_addr;
    logic [22:0] o_mem_addr;
    logic clash;
    logic [7:0] hits;
    int n_fail = 0;
    int checks = 0;
    int n_slot = 0;
    // Address, straps (debug board, swap), selects, slot selects, width
    row_t rows[34] = '{
        '{32'h00000000,2'h0,10'h200,3'h7,1'h0},
        '{32'h00800001,2'h1,10'h200,3'h7,1'h0},
        '{32'h01000000,2'h1,10'h000,3'h7,1'h0},
        '{32'h00000010,2'h2,10'h200,3'h7,1'h0},
        '{32'h00800000,2'h2,10'h100,3'h7,1'h0},
        '{32'h00000000,2'h3,10'h100,3'h7,1'h0},
        '{32'h00FFFFFF,2'h3,10'h200,3'h7,1'h0},
        '{32'h03FFFFFF,2'h2,10'h000,3'h7,1'h0},
        '{32'h02000000,2'h3,10'h000,3'h7,1'h0},
        '{32'h04000000,2'h0,10'h000,3'h3,1'h0},
        '{32'h07FFFFFF,2'h0,10'h000,3'h3,1'h0},
        '{32'h10000000,2'h0,10'h000,3'h5,1'h0},
        '{32'h13FFFFFF,2'h0,10'h000,3'h5,1'h0},
        '{32'h14000000,2'h0,10'h000,3'h6,1'h0},
        '{32'h17FFFFFF,2'h0,10'h000,3'h6,1'h0},
        '{32'h08000000,2'h0,10'h080,3'h7,1'h0},
        '{32'h0BFFFFFF,2'h0,10'h080,3'h7,1'h0},
        '{32'h0FFFFFFF,2'h0,10'h040,3'h7,1'h1},
        '{32'h18000000,2'h0,10'h020,3'h7,1'h0},
        '{32'h19FFFFFF,2'h0,10'h020,3'h7,1'h0},
        '{32'h1A000000,2'h0,10'h010,3'h7,1'h0},
        '{32'h1A7FFFFF,2'h0,10'h010,3'h7,1'h0},
        '{32'h1A800000,2'h0,10'h008,3'h7,1'h0},
        '{32'h1AFFFFFF,2'h0,10'h008,3'h7,1'h0},
        '{32'h1B000000,2'h0,10'h004,3'h7,1'h0},
        '{32'h1B7FFFFF,2'h0,10'h004,3'h7,1'h0},
        '{32'h1B800000,2'h0,10'h000,3'h7,1'h0},
        '{32'h1C000000,2'h0,10'h000,3'h7,1'h0},
        '{32'hFD000000,2'h0,10'h002,3'h7,1'h0},
        '{32'hFE200000,2'h0,10'h001,3'h7,1'h0},
        '{32'hFE1FFFFF,2'h0,10'h000,3'h7,1'h0},
        '{32'hFE23FFFF,2'h0,10'h001,3'h7,1'h0},
        '{32'hFE240000,2'h0,10'h000,3'h7,1'h0},
        '{32'h20000000,2'h0,10'h000,3'h7,1'h0}};

    always #2 i_core_clk = ~i_core_clk;

    area_decoder i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_access(i_access), .i_addr(i_addr),
        .i_debug_board_fitted(i_debug_board_fitted),
        .i_eprom_first(i_eprom_first), .o_dev_sel(o_dev_sel),
        .o_slot_sel(o_slot_sel), .o_bus_32bit(o_bus_32bit),
        .o_slot_addr(o_slot_addr), .o_mem_addr(o_mem_addr));

    slot_board_model i_board (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_slot_sel(o_slot_sel), .o_clash(clash), .o_hits(hits));

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic fail(input string msg);
    begin
        n_fail++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    end
    endtask : fail

    task automatic chk(input dev_sel_t d, input slot_sel_t s, input logic w);
    begin
        checks++;
        if (o_dev_sel !== d || o_slot_sel !== s || o_bus_32bit !== w)
            fail("wrong selects");
    end
    endtask : chk

    task automatic end_sim();
    begin
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask : end_sim

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial
    begin
        #20000;
        fail("timeout");
        end_sim();
    end

    initial
    begin
        repeat (3) @(posedge i_core_clk);
        #1;
        chk(DEV_IDLE, SLOT_IDLE, 1'h0);
        @(posedge i_core_clk);
        i_rst <= 1'h0;
        // Back to back, then reset mid-run, then a dropped access
        @(posedge i_core_clk);
        i_access <= 1'h1;
        i_addr <= 32'h04012345;
        @(posedge i_core_clk);
        i_addr <= 32'h0C000000;
        #1;
        chk(DEV_IDLE, 3'h3, 1'h0);
        checks++;
        if (o_slot_addr !== 19'h12345) fail("slot offset");
        @(posedge i_core_clk);
        #1;
        chk(10'h040, SLOT_IDLE, 1'h1);
        @(posedge i_core_clk);
        i_rst <= 1'h1;
        #1;
        chk(DEV_IDLE, SLOT_IDLE, 1'h0);
        @(posedge i_core_clk);
        i_rst <= 1'h0;
        @(posedge i_core_clk);
        i_access <= 1'h0;
        #1;
        chk(10'h040, SLOT_IDLE, 1'h1);
        @(posedge i_core_clk);
        #1;
        chk(DEV_IDLE, SLOT_IDLE, 1'h0);
        // Table of single accesses
        foreach (rows[i])
        begin
            @(posedge i_core_clk);
            i_access <= 1'h1;
            i_addr <= rows[i].addr;
            {i_debug_board_fitted, i_eprom_first} <= rows[i].sw;
            @(posedge i_core_clk);
            i_access <= 1'h0;
            #1;
            chk(rows[i].dev, rows[i].slot, rows[i].b32);
            n_slot += int'(rows[i].slot !== SLOT_IDLE);
            checks++;
            if (o_slot_addr !== rows[i].addr[18:0]) fail("offset");
            checks++;
            if (o_mem_addr !== rows[i].addr[22:0]) fail("mem offset");
        end
        @(posedge i_core_clk);
        #1;
        checks++;
        if (clash !== 1'h0 || hits !== 8'(n_slot)) fail("board");
        end_sim();
    end
endmodule : area_decoder_tb_top
